// *** src/dtm_pkg.sv ***
// Purpose: constants and types for the dual timer run and mode control
// Assumes: 32-bit APB, register index times four gives the byte address
// Notes: all control and counter state clears to zero on any reset
package dtm_pkg;

  // ==========================================================
  // register indices (byte address is index times four)
  localparam logic [7:0] DTM_IDX_CTRL = 8'h88;
  localparam logic [7:0] DTM_IDX_MODE = 8'h89;
  localparam logic [7:0] DTM_IDX_A_LO = 8'h8a;
  localparam logic [7:0] DTM_IDX_A_HI = 8'h8b;
  localparam logic [7:0] DTM_IDX_B_LO = 8'h8c;
  localparam logic [7:0] DTM_IDX_B_HI = 8'h8d;
  localparam logic [7:0] DTM_IDX_STAT = 8'h8e;
  localparam logic [7:0] DTM_IDX_MASK = 8'h8f;

  // ==========================================================
  // run_and_flag_control bit positions
  localparam int DTM_OVF_B = 7;
  localparam int DTM_RUN_B = 6;
  localparam int DTM_OVF_A = 5;
  localparam int DTM_RUN_A = 4;
  localparam int DTM_EXT1_PEND = 3;
  localparam int DTM_EXT1_SENSE = 2;
  localparam int DTM_EXT0_PEND = 1;
  localparam int DTM_EXT0_SENSE = 0;

  // ==========================================================
  // count_mode_config bit positions
  localparam int DTM_QUAL_B = 7;
  localparam int DTM_CT_B = 6;
  localparam int DTM_MODE_B_LSB = 4;
  localparam int DTM_QUAL_A = 3;
  localparam int DTM_CT_A = 2;
  localparam int DTM_MODE_A_LSB = 0;

  // ==========================================================
  // pin vector and interrupt status bit positions
  localparam int DTM_PIN_A = 0;
  localparam int DTM_PIN_B = 1;
  localparam int DTM_PIN_X0 = 2;
  localparam int DTM_PIN_X1 = 3;
  localparam int DTM_ST_OVF_A = 0;
  localparam int DTM_ST_OVF_B = 1;
  localparam int DTM_ST_EXT0 = 2;
  localparam int DTM_ST_EXT1 = 3;

  // ==========================================================
  // reset values
  localparam logic [7:0] DTM_CTRL_RST = 8'h00;
  localparam logic [7:0] DTM_MODE_RST = 8'h00;
  localparam logic [7:0] DTM_CNT_RST = 8'h00;
  localparam logic [3:0] DTM_MASK_RST = 4'h0;
  // pins idle high; capture starts there so no false level or edge
  localparam logic [3:0] DTM_PIN_RST = 4'hf;

  // ==========================================================
  // counting modes
  typedef enum logic [1:0] {
    DTM_M13 = 2'b00,
    DTM_M16 = 2'b01,
    DTM_MRELOAD = 2'b10,
    DTM_MSPLIT = 2'b11
  } dtm_mode_e;

endpackage

// *** src/dtm_timer_ctrl.sv ***
// Purpose: run/stop, gating, mode select and counting for two timers
// Assumes: APB slave on pclk, zero wait states, pins asynchronous
// Notes: counter byte writes win over a count in the same cycle

// Behaviour
// - overflow sets unit flag, bits 7 and 5
// - overflow flag holds until software clears it
// - software one on flag raises timer interrupt
// - run bits 6 and 4 start or stop
// - qualify zero: run bit alone enables counting
// - qualify one: needs run bit and pin high
// - select bit picks timer zero, counter one
// - mode fields at bits 5-4 and 1-0
// - mode 00 is 13-bit, low top ignored
// - mode 01 is full 16-bit counter
// - mode 10 is 8-bit with reload
// - mode 11 splits unit A only
// - external request flags at bits 3, 1
// - external sense select at bits 2, 0
// - counter mode counts pin falling edges
// - reload keeps high byte, sets flag
// - run resumes from held count value
// - split high byte uses B run, flag
module dtm_timer_ctrl
  import dtm_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pulse_in_pin_a,
  input wire logic pulse_in_pin_b,
  input wire logic [1:0] ext_irq_pin,
  output logic pin_a_count_sel,
  output logic pin_b_count_sel,
  output logic tmr_a_irq_req,
  output logic tmr_b_irq_req,
  output logic [1:0] ext_irq_req,
  output logic irq
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] a_lo;
    logic [7:0] a_hi;
    logic [7:0] b_lo;
    logic [7:0] b_hi;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] pin_lvl;
    logic [3:0] status;
    logic [3:0] mask;
    logic [31:0] rdata;
    logic err;
  } dtm_state_s;

  dtm_state_s r_reg;
  dtm_state_s r_next;

  // one count step: returns {overflow, high, low}
  function automatic logic [16:0] dtm_step(
    input logic [7:0] lo,
    input logic [7:0] hi,
    input dtm_mode_e m
  );
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    logic [16:0] res;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h0_0001;
    s8 = {1'b0, lo} + 9'h001;
    res = {1'b0, hi, lo};
    unique case (m)
      // top three low bits neither count nor wrap
      DTM_M13: res = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
      DTM_M16: res = s16;
      DTM_MRELOAD: begin
        // wrap reloads low byte, high byte untouched
        if (s8[8]) begin
          res = {1'b1, hi, hi};
        end else begin
          res = {1'b0, hi, s8[7:0]};
        end
      end
      DTM_MSPLIT: res = {s8[8], hi, s8[7:0]};
    endcase
    return res;
  endfunction

  // ==========================================================
  // combinational next state
  logic [3:0] fall;
  logic [9:0] idx_full;
  logic hit_ok;
  logic setup;
  logic wr;
  logic rd;
  dtm_mode_e mode_a;
  dtm_mode_e mode_b;
  logic split;
  logic tick_a;
  logic tick_b;
  logic run_a;
  logic run_b;
  logic run_ah;
  logic b_flag_ok;
  logic [16:0] step_a;
  logic [16:0] step_b;
  logic [8:0] step_ah;
  logic ovf_a;
  logic ovf_b;
  logic sw_ovf_a;
  logic sw_ovf_b;
  logic [1:0] ext_set;
  logic [3:0] ev;
  logic [31:0] rd_mux;
  logic rd_hit;

  always_comb begin
    r_next = r_reg;

    // three-stage pin capture; level moves once stages two and three agree
    r_next.sync1 = {ext_irq_pin, pulse_in_pin_b, pulse_in_pin_a};
    r_next.sync2 = r_reg.sync1;
    r_next.sync3 = r_reg.sync2;
    for (int i = 0; i < 4; i++) begin
      if (r_reg.sync2[i] == r_reg.sync3[i]) begin
        r_next.pin_lvl[i] = r_reg.sync3[i];
      end
    end
    fall = r_reg.pin_lvl & ~r_next.pin_lvl;

    // bus decode
    idx_full = paddr[ADDR_W-1:2];
    hit_ok = (idx_full[9:8] == 2'b00) && (paddr[1:0] == 2'b00);
    setup = psel & ~penable;
    wr = psel & penable & pwrite;
    rd = psel & penable & ~pwrite;

    mode_a = dtm_mode_e'(r_reg.mode[DTM_MODE_A_LSB +: 2]);
    mode_b = dtm_mode_e'(r_reg.mode[DTM_MODE_B_LSB +: 2]);
    split = (mode_a == DTM_MSPLIT);

    // unit A: clock or pin edge, run bit, optional pin qualify
    tick_a = r_reg.mode[DTM_CT_A] ? fall[DTM_PIN_A] : 1'b1;
    run_a = r_reg.ctrl[DTM_RUN_A] & tick_a &
      (~r_reg.mode[DTM_QUAL_A] | r_reg.pin_lvl[DTM_PIN_X0]);

    // unit B: while A is split, B free-runs on the clock unless its own mode is 11, and flags nothing
    if (split) begin
      tick_b = 1'b1;
      run_b = (mode_b != DTM_MSPLIT);
      b_flag_ok = 1'b0;
    end else begin
      tick_b = r_reg.mode[DTM_CT_B] ? fall[DTM_PIN_B] : 1'b1;
      run_b = r_reg.ctrl[DTM_RUN_B] & tick_b &
        (~r_reg.mode[DTM_QUAL_B] | r_reg.pin_lvl[DTM_PIN_X1]) &
        (mode_b != DTM_MSPLIT);
      b_flag_ok = 1'b1;
    end
    run_ah = split & r_reg.ctrl[DTM_RUN_B];

    // counting continues from the held value; nothing clears on start
    step_a = dtm_step(r_reg.a_lo, r_reg.a_hi, mode_a);
    step_b = dtm_step(r_reg.b_lo, r_reg.b_hi, mode_b);
    step_ah = {1'b0, r_reg.a_hi} + 9'h001;
    ovf_a = 1'b0;
    ovf_b = 1'b0;
    if (run_a) begin
      r_next.a_lo = step_a[7:0];
      if (!split) begin
        r_next.a_hi = step_a[15:8];
      end
      ovf_a = step_a[16];
    end
    if (run_ah) begin
      r_next.a_hi = step_ah[7:0];
      ovf_b = step_ah[8];
    end
    if (run_b) begin
      r_next.b_lo = step_b[7:0];
      r_next.b_hi = step_b[15:8];
      ovf_b = ovf_b | (step_b[16] & b_flag_ok);
    end

    // software writes; a counter byte write overrides a count
    sw_ovf_a = 1'b0;
    sw_ovf_b = 1'b0;
    if (wr && hit_ok) begin
      unique case (idx_full[7:0])
        DTM_IDX_CTRL: begin
          r_next.ctrl = pwdata[7:0];
          sw_ovf_a = pwdata[DTM_OVF_A] & ~r_reg.ctrl[DTM_OVF_A];
          sw_ovf_b = pwdata[DTM_OVF_B] & ~r_reg.ctrl[DTM_OVF_B];
        end
        DTM_IDX_MODE: r_next.mode = pwdata[7:0];
        DTM_IDX_A_LO: r_next.a_lo = pwdata[7:0];
        DTM_IDX_A_HI: r_next.a_hi = pwdata[7:0];
        DTM_IDX_B_LO: r_next.b_lo = pwdata[7:0];
        DTM_IDX_B_HI: r_next.b_hi = pwdata[7:0];
        DTM_IDX_MASK: r_next.mask = pwdata[3:0];
        default: begin
        end
      endcase
    end

    // hardware sets win over a software clear in the same cycle
    if (ovf_a) begin
      r_next.ctrl[DTM_OVF_A] = 1'b1;
    end
    if (ovf_b) begin
      r_next.ctrl[DTM_OVF_B] = 1'b1;
    end

    // external request flags: low level or falling edge per sense bit
    ext_set[0] = r_reg.ctrl[DTM_EXT0_SENSE] ? fall[DTM_PIN_X0]
                                            : ~r_reg.pin_lvl[DTM_PIN_X0];
    ext_set[1] = r_reg.ctrl[DTM_EXT1_SENSE] ? fall[DTM_PIN_X1]
                                            : ~r_reg.pin_lvl[DTM_PIN_X1];
    if (ext_set[0]) begin
      r_next.ctrl[DTM_EXT0_PEND] = 1'b1;
    end
    if (ext_set[1]) begin
      r_next.ctrl[DTM_EXT1_PEND] = 1'b1;
    end

    // sticky status events; a read clears, a same-cycle event survives
    ev = '0;
    ev[DTM_ST_OVF_A] = ovf_a | sw_ovf_a;
    ev[DTM_ST_OVF_B] = ovf_b | sw_ovf_b;
    ev[DTM_ST_EXT0] = ext_set[0] & ~r_reg.ctrl[DTM_EXT0_PEND];
    ev[DTM_ST_EXT1] = ext_set[1] & ~r_reg.ctrl[DTM_EXT1_PEND];
    if (rd && hit_ok && idx_full[7:0] == DTM_IDX_STAT) begin
      r_next.status = ev;
    end else begin
      r_next.status = r_reg.status | ev;
    end

    // read data captured in setup so it stands through the access phase
    rd_mux = '0;
    rd_hit = hit_ok;
    unique case (idx_full[7:0])
      DTM_IDX_CTRL: rd_mux[7:0] = r_reg.ctrl;
      DTM_IDX_MODE: rd_mux[7:0] = r_reg.mode;
      DTM_IDX_A_LO: rd_mux[7:0] = r_reg.a_lo;
      DTM_IDX_A_HI: rd_mux[7:0] = r_reg.a_hi;
      DTM_IDX_B_LO: rd_mux[7:0] = r_reg.b_lo;
      DTM_IDX_B_HI: rd_mux[7:0] = r_reg.b_hi;
      DTM_IDX_STAT: rd_mux[3:0] = r_reg.status;
      DTM_IDX_MASK: rd_mux[3:0] = r_reg.mask;
      default: rd_hit = 1'b0;
    endcase
    if (setup) begin
      r_next.rdata = rd_hit ? rd_mux : 32'h0000_0000;
      r_next.err = ~rd_hit;
    end
  end

  // ==========================================================
  // registers; every reset source lands here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.ctrl <= DTM_CTRL_RST;
      r_reg.mode <= DTM_MODE_RST;
      r_reg.a_lo <= DTM_CNT_RST;
      r_reg.a_hi <= DTM_CNT_RST;
      r_reg.b_lo <= DTM_CNT_RST;
      r_reg.b_hi <= DTM_CNT_RST;
      r_reg.mask <= DTM_MASK_RST;
      // idle-high start: a zero here would fake low pins after reset
      r_reg.sync1 <= DTM_PIN_RST;
      r_reg.sync2 <= DTM_PIN_RST;
      r_reg.sync3 <= DTM_PIN_RST;
      r_reg.pin_lvl <= DTM_PIN_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // outputs
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign prdata = r_reg.rdata;
  assign pslverr = r_reg.err & psel & penable;
  // pins serve the counter only when running in counter mode
  assign pin_a_count_sel = r_reg.ctrl[DTM_RUN_A] & r_reg.mode[DTM_CT_A];
  assign pin_b_count_sel = r_reg.ctrl[DTM_RUN_B] & r_reg.mode[DTM_CT_B] &
    ~split;
  assign tmr_a_irq_req = r_reg.ctrl[DTM_OVF_A];
  assign tmr_b_irq_req = r_reg.ctrl[DTM_OVF_B];
  assign ext_irq_req = {r_reg.ctrl[DTM_EXT1_PEND], r_reg.ctrl[DTM_EXT0_PEND]};
  assign irq = |(r_reg.status & r_reg.mask);

endmodule

// *** test/dtm_checker.sv ***
// Purpose: port assertions for the dual timer control block
// Assumes: ctrl at byte 0x220, byte 0x200 unmapped
// Notes: stimulus keeps wraps off the edge of a flag clear
module dtm_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic tmr_a_irq_req,
  input wire logic tmr_b_irq_req,
  input wire logic [1:0] ext_irq_req,
  input wire logic irq
);
  // ==========================================
  // access decode
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wc;
  logic rc;
  // ctrl write and read access phases
  assign wc = psel && penable && pwrite && paddr == 12'h220;
  assign rc = psel && penable && !pwrite && paddr == 12'h220;
  // ==========================================
  // properties
  AST_RST: assert property ($rose(presetn) |-> !irq && !tmr_a_irq_req
    && !tmr_b_irq_req && ext_irq_req == 2'b00) else $error("not clear");
  AST_HOLD_A: assert property (tmr_a_irq_req && !wc |=> tmr_a_irq_req)
    else $error("flag a dropped");
  AST_HOLD_B: assert property (tmr_b_irq_req && !wc |=> tmr_b_irq_req)
    else $error("flag b dropped");
  AST_CLR: assert property (wc && pwdata[7:4] == 4'h0 |=>
    !tmr_a_irq_req && !tmr_b_irq_req) else $error("flag not cleared");
  AST_SET: assert property (wc && pwdata[7] && pwdata[5] |=>
    tmr_a_irq_req && tmr_b_irq_req) else $error("flag not set");
  AST_EXT: assert property (wc && pwdata[3] && pwdata[1] |=>
    ext_irq_req == 2'b11) else $error("pending not set");
  AST_RD: assert property (rc |-> prdata[31:8] == 24'h0 &&
    prdata[7] == $past(tmr_b_irq_req) && prdata[5] == $past(tmr_a_irq_req)
    && prdata[3] == $past(ext_irq_req[1])
    && prdata[1] == $past(ext_irq_req[0])) else $error("ctrl read off");
  AST_ERR: assert property (psel && penable && paddr == 12'h200 |-> pslverr)
    else $error("no error");
  // main scenarios
  cover property ($rose(tmr_a_irq_req));
  cover property (rc && prdata[5]);
  cover property (psel && penable && pslverr);
endmodule

bind dtm_timer_ctrl dtm_checker u_dtm_checker (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .tmr_a_irq_req,
  .tmr_b_irq_req, .ext_irq_req, .irq);

// *** test/dtm_pins.sv ***
// Purpose: count pulse and gate level source at the pins
// Assumes: pins idle high, as with a pull-up
// Notes: one falling edge per eight cycles inside a burst
module dtm_pins (
  input wire logic pclk,
  input wire logic burst,
  input wire logic [1:0] gate,
  output logic pulse_in_pin_a,
  output logic pulse_in_pin_b,
  output logic [1:0] ext_irq_pin
);
  logic [2:0] ph_reg;
  // ==========================================
  // phase runs only inside a burst
  always_ff @(posedge pclk) ph_reg <= burst ? ph_reg + 3'h1 : 3'h0;
  // high half first, so a burst never opens with an edge
  assign pulse_in_pin_b = ~(burst & ph_reg[2]);
  assign pulse_in_pin_a = 1'b1;
  assign ext_irq_pin = gate;
endmodule

// *** test/testbench.sv ***
// Purpose: self-checking bench for the dual timer control block
// Assumes: zero-wait APB, byte address is four times the index
// Notes: reads are queued by the driver and checked by a monitor
module testbench
  import dtm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, burst = 1'b0, pready, pslverr, bsel, irq;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [1:0] gate = 2'b11, ext_irq_pin;
  logic pulse_in_pin_a, pulse_in_pin_b;
  logic [32:0] exp_q[$];
  logic [15:0] rs = 16'h0012;
  int bad_count = 0;
  int checks_done = 0;
  always #5 pclk = ~pclk;
  dtm_timer_ctrl u_dtm_timer_ctrl (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pulse_in_pin_a,
    .pulse_in_pin_b, .ext_irq_pin, .pin_a_count_sel(), .pin_b_count_sel(bsel),
    .tmr_a_irq_req(), .tmr_b_irq_req(), .ext_irq_req(), .irq);
  dtm_pins u_dtm_pins (.pclk, .burst, .gate, .pulse_in_pin_a,
    .pulse_in_pin_b, .ext_irq_pin);
  // ==========================================
  // compare, verdict, reference model
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // steps n counts; top bit says a wrap was seen
  function automatic logic [16:0] adv(input logic [1:0] md,
      input logic [15:0] v, input int n);
    logic f;
    f = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (md == 2'b01) begin
        f |= v == 16'hffff;
        v = v + 16'h1;
      end else if (md == 2'b10) begin
        f |= v[7:0] == 8'hff;
        v[7:0] = (v[7:0] == 8'hff) ? v[15:8] : v[7:0] + 8'h1;
      end else begin
        f |= {v[15:8], v[4:0]} == 13'h1fff;
        {v[15:8], v[4:0]} = {v[15:8], v[4:0]} + 13'h1;
      end
    end
    return {f, v};
  endfunction
  // ==========================================
  // bus master; one setup cycle, then holds the access phase until pready at an edge
  task automatic apb(input logic [7:0] idx, input logic w,
      input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= 32'(d);
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back(33'(e));
    apb(idx, 1'b0, 8'h0);
  endtask
  // read results taken at the access edge
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (exp_q.size() == 0) bad_count++;
      else chk({pslverr, prdata}, exp_q.pop_front());
    end
  end
  // ==========================================
  // main sequence
  initial begin
    logic [1:0] md;
    logic [15:0] v;
    logic [16:0] e;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(DTM_IDX_CTRL, 8'h00);
    rd(DTM_IDX_MODE, 8'h00);
    exp_q.push_back({1'b1, 32'h0});
    apb(8'h80, 1'b0, 8'h0);
    wr(DTM_IDX_MASK, 8'h01);
    wr(DTM_IDX_CTRL, 8'ha0);
    chk(33'(irq), 33'h1);
    rd(DTM_IDX_STAT, 8'h03);
    chk(33'(irq), 33'h0);
    wr(DTM_IDX_CTRL, 8'haa);
    rd(DTM_IDX_CTRL, 8'haa);
    wr(DTM_IDX_CTRL, 8'h05);
    rd(DTM_IDX_CTRL, 8'h05);
    // unit A timer, preload near the wrap, ten counts in all
    for (int m = 0; m < 3; m++) begin
      md = m[1:0];
      rs = lfsr(rs);
      v = {md == 2'b10 ? {1'b0, rs[14:8]} : 8'hff,
           md == 2'b00 ? rs[7:5] : 3'b111, 2'b11, rs[2:0]};
      wr(DTM_IDX_MODE, {6'h0, md});
      wr(DTM_IDX_A_LO, v[7:0]);
      wr(DTM_IDX_A_HI, v[15:8]);
      wr(DTM_IDX_CTRL, 8'h10);
      repeat (4) @(posedge pclk);
      e = adv(md, v, 5);
      rd(DTM_IDX_CTRL, {2'b00, e[16], 5'h10});
      wr(DTM_IDX_CTRL, 8'h00);
      e = adv(md, v, 10);
      rd(DTM_IDX_A_LO, e[7:0]);
      rd(DTM_IDX_A_HI, e[15:8]);
    end
    // unit B counts pin falls only while its gate pin is high
    wr(DTM_IDX_MODE, 8'hd0);
    gate <= 2'b01;
    wr(DTM_IDX_CTRL, 8'h40);
    chk(33'(bsel), 33'h1);
    burst <= 1'b1;
    repeat (24) @(posedge pclk);
    burst <= 1'b0;
    gate <= 2'b11;
    repeat (8) @(posedge pclk);
    burst <= 1'b1;
    repeat (40) @(posedge pclk);
    burst <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(DTM_IDX_B_LO, 8'h05);
    end_sim();
  end
endmodule
